// ### aec_seq_pkg.sv
// Register map, field layout and reset values of the exposure status and sequencer configuration bank.
package aec_seq_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets on the configuration port.
   localparam logic [7:0]  PIX_COUNT_LOW_ADDR   = 8'hb8;
   localparam logic [7:0]  PIX_COUNT_HIGH_ADDR  = 8'hb9;
   localparam logic [7:0]  AEC_AVERAGE_ADDR     = 8'hba;
   localparam logic [7:0]  AEC_EXPOSURE_ADDR    = 8'hbb;
   localparam logic [7:0]  AEC_GAIN_ADDR        = 8'hbc;
   localparam logic [7:0]  RSVD_STATUS_ADDR     = 8'hbd;
   localparam logic [7:0]  SEQ_GENERAL_ADDR     = 8'hc0;
   localparam logic [7:0]  SEQ_DELAY_ADDR       = 8'hc1;

   ////////////////////////////////////////////////////////////////////////////
   // Field widths and positions.
   localparam int          ADDR_W               = 8;
   localparam int          DATA_W               = 16;
   localparam int          PIX_COUNT_W          = 19;
   localparam int          AVERAGE_W            = 10;
   localparam int          EXPOSURE_W           = 16;
   localparam int          AMP_W                = 2;
   localparam int          DGAIN_W              = 12;
   localparam int          DELAY_W              = 8;
   localparam int          AVG_LOCK_BIT         = 12;
   localparam int          GAIN_AMP1_LSB        = 0;
   localparam int          GAIN_AMP2_LSB        = 2;
   localparam int          GAIN_DIGITAL_LSB     = 4;
   localparam int          CFG_ENABLE_BIT       = 0;
   localparam int          CFG_ROLLING_BIT      = 1;
   localparam int          CFG_TRIGGERED_BIT    = 4;
   localparam int          CFG_SLAVE_BIT        = 5;
   localparam int          CFG_DELAY_EN_BIT     = 6;
   localparam int          CFG_SUBSAMPLE_BIT    = 7;
   localparam int          CFG_BINNING_BIT      = 8;
   localparam int          DLY_XLEN_LSB         = 0;
   localparam int          DLY_READOUT_LSB      = 8;

   ////////////////////////////////////////////////////////////////////////////
   // Writable bit masks and reset values.
   localparam logic [15:0] SEQ_GENERAL_MASK     = 16'h01f3;
   localparam logic [15:0] SEQ_GENERAL_RESET    = 16'h0000;
   localparam logic [15:0] SEQ_DELAY_RESET      = 16'h0000;
   localparam logic [15:0] STATUS_RESET         = 16'h0000;

endpackage : aec_seq_pkg

// ### aec_status_latch.sv
// Snapshot of the exposure loop results, taken as one coherent set on each update pulse.
`timescale 1ns/1ns
`default_nettype none
module aec_status_latch
   import aec_seq_pkg::*;
#(
   parameter int COUNT_W = PIX_COUNT_W
)
(
   input  wire logic               clk_i,
   input  wire logic               sys_rst_i,
   input  wire logic               update_i,
   input  wire logic [COUNT_W-1:0] count_i,
   input  wire logic [AVERAGE_W-1:0] average_i,
   input  wire logic               locked_i,
   input  wire logic [EXPOSURE_W-1:0] exposure_i,
   input  wire logic [AMP_W-1:0]   amp_first_i,
   input  wire logic [AMP_W-1:0]   amp_second_i,
   input  wire logic [DGAIN_W-1:0] digital_gain_i,
   output logic      [COUNT_W-1:0] count_o,
   output logic      [AVERAGE_W-1:0] average_o,
   output logic                    locked_o,
   output logic      [EXPOSURE_W-1:0] exposure_o,
   output logic      [AMP_W-1:0]   amp_first_o,
   output logic      [AMP_W-1:0]   amp_second_o,
   output logic      [DGAIN_W-1:0] digital_gain_o
);

   ////////////////////////////////////////////////////////////////////////////
   // The whole set is taken on one edge so software never reads a mixed result.
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         count_o        <= '0;
         average_o      <= '0;
         locked_o       <= 1'b0;
         exposure_o     <= '0;
         amp_first_o    <= '0;
         amp_second_o   <= '0;
         digital_gain_o <= '0;
      end
      else if (update_i)
      begin
         count_o        <= count_i;
         average_o      <= average_i;
         locked_o       <= locked_i;
         exposure_o     <= exposure_i;
         amp_first_o    <= amp_first_i;
         amp_second_o   <= amp_second_i;
         digital_gain_o <= digital_gain_i;
      end
   end

endmodule : aec_status_latch
`default_nettype wire

// ### readout_delay.sv
// Counter that places the start of pixel readout after the end of the row overhead period.
`timescale 1ns/1ns
`default_nettype none
module readout_delay
   import aec_seq_pkg::*;
#(
   parameter int LEN_W = DELAY_W
)
(
   input  wire logic             clk_i,
   input  wire logic             sys_rst_i,
   input  wire logic             run_i,
   input  wire logic             overhead_end_i,
   input  wire logic             delay_en_i,
   input  wire logic [LEN_W-1:0] delay_len_i,
   output logic                  start_o
);

   logic             counting;
   logic [LEN_W-1:0] remain;

   wire  skip_delay = !delay_en_i || (delay_len_i == '0);
   wire  last_count = counting && (remain == LEN_W'(1));

   ////////////////////////////////////////////////////////////////////////////
   // A new overhead end restarts the wait; dropping run aborts it.
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i || !run_i)
      begin
         counting <= 1'b0;
         remain   <= '0;
         start_o  <= 1'b0;
      end
      else if (overhead_end_i)
      begin
         counting <= !skip_delay;
         remain   <= delay_len_i;
         start_o  <= skip_delay;
      end
      else
      begin
         counting <= counting && !last_count;
         remain   <= counting ? remain - LEN_W'(1) : remain;
         start_o  <= last_count;
      end
   end

endmodule : readout_delay
`default_nettype wire

// ### aec_seq_regs.sv
// Exposure loop status registers and sequencer general configuration behind the configuration port.
`timescale 1ns/1ns
`default_nettype none
module aec_seq_regs
   import aec_seq_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  sys_rst_i,
   input  wire logic [ADDR_W-1:0]     reg_addr_i,
   input  wire logic [DATA_W-1:0]     reg_wdata_i,
   input  wire logic                  reg_wr_i,
   input  wire logic                  reg_rd_i,
   output logic      [DATA_W-1:0]     reg_rdata_o,
   output logic                       reg_rvalid_o,
   input  wire logic                  aec_update_i,
   input  wire logic [PIX_COUNT_W-1:0] aec_pixel_count_i,
   input  wire logic [AVERAGE_W-1:0]  aec_average_i,
   input  wire logic                  aec_locked_i,
   input  wire logic [EXPOSURE_W-1:0] aec_exposure_i,
   input  wire logic [AMP_W-1:0]      analog_amp_first_i,
   input  wire logic [AMP_W-1:0]      analog_amp_second_i,
   input  wire logic [DGAIN_W-1:0]    aec_digital_gain_i,
   input  wire logic                  row_overhead_period_end_i,
   output logic                       seq_enable_o,
   output logic                       rolling_shutter_o,
   output logic                       triggered_mode_o,
   output logic                       slave_mode_o,
   output logic                       subsample_o,
   output logic                       binning_o,
   output logic      [DELAY_W-1:0]    rs_x_length_o,
   output logic                       readout_start_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Status snapshot from the exposure loop.
   logic [PIX_COUNT_W-1:0] pix_count;
   logic [AVERAGE_W-1:0]   average;
   logic                   locked;
   logic [EXPOSURE_W-1:0]  exposure;
   logic [AMP_W-1:0]       amp_first;
   logic [AMP_W-1:0]       amp_second;
   logic [DGAIN_W-1:0]     digital_gain;

   aec_status_latch #(
      .COUNT_W        (PIX_COUNT_W)
   ) status_latch (
      .clk_i          (clk_i),
      .sys_rst_i      (sys_rst_i),
      .update_i       (aec_update_i),
      .count_i        (aec_pixel_count_i),
      .average_i      (aec_average_i),
      .locked_i       (aec_locked_i),
      .exposure_i     (aec_exposure_i),
      .amp_first_i    (analog_amp_first_i),
      .amp_second_i   (analog_amp_second_i),
      .digital_gain_i (aec_digital_gain_i),
      .count_o        (pix_count),
      .average_o      (average),
      .locked_o       (locked),
      .exposure_o     (exposure),
      .amp_first_o    (amp_first),
      .amp_second_o   (amp_second),
      .digital_gain_o (digital_gain)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Status words as software sees them; unused bits are tied to zero.
   wire [DATA_W-1:0] pix_low_word  = pix_count[15:0];
   wire [DATA_W-1:0] pix_high_word = {13'h0000, pix_count[PIX_COUNT_W-1:16]};
   wire [DATA_W-1:0] average_word  = {3'h0, locked, 2'h0, average};
   wire [DATA_W-1:0] exposure_word = exposure;
   wire [DATA_W-1:0] gain_word     = {digital_gain, amp_second, amp_first};

   ////////////////////////////////////////////////////////////////////////////
   // Status offsets are read-only; a write that lands on them is dropped.
   function automatic logic is_status_addr(input logic [ADDR_W-1:0] addr);
      return (addr >= PIX_COUNT_LOW_ADDR) && (addr <= RSVD_STATUS_ADDR);
   endfunction : is_status_addr

   ////////////////////////////////////////////////////////////////////////////
   // Writable configuration registers.
   logic [DATA_W-1:0] general_cfg;
   logic [DATA_W-1:0] delay_cfg;

   // Write strobes per register; only the two configuration words take writes.
   wire wr_general = reg_wr_i && (reg_addr_i == SEQ_GENERAL_ADDR);
   wire wr_delay   = reg_wr_i && (reg_addr_i == SEQ_DELAY_ADDR);
   wire wr_status  = reg_wr_i && is_status_addr(reg_addr_i);

   // Only documented bits are stored, so reserved ones read back as zero.
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         general_cfg <= SEQ_GENERAL_RESET;
         delay_cfg   <= SEQ_DELAY_RESET;
      end
      else
      begin
         if (wr_general)
            general_cfg <= reg_wdata_i & SEQ_GENERAL_MASK;
         if (wr_delay)
            delay_cfg <= reg_wdata_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode; trigger and slave only apply under global shutter.
   wire cfg_enable    = general_cfg[CFG_ENABLE_BIT];
   wire cfg_rolling   = general_cfg[CFG_ROLLING_BIT];
   wire cfg_triggered = general_cfg[CFG_TRIGGERED_BIT] && !cfg_rolling;
   wire cfg_slave     = general_cfg[CFG_SLAVE_BIT] && !cfg_rolling;
   wire cfg_delay_en  = general_cfg[CFG_DELAY_EN_BIT];
   wire cfg_subsample = general_cfg[CFG_SUBSAMPLE_BIT];
   wire cfg_binning   = general_cfg[CFG_BINNING_BIT];
   wire [DELAY_W-1:0] readout_delay_len = delay_cfg[DLY_READOUT_LSB +: DELAY_W];

   // Mode outputs are registered so the sequencer sees clean levels.
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         seq_enable_o      <= 1'b0;
         rolling_shutter_o <= 1'b0;
         triggered_mode_o  <= 1'b0;
         slave_mode_o      <= 1'b0;
         subsample_o       <= 1'b0;
         binning_o         <= 1'b0;
         rs_x_length_o     <= '0;
      end
      else
      begin
         seq_enable_o      <= cfg_enable;
         rolling_shutter_o <= cfg_rolling;
         triggered_mode_o  <= cfg_triggered;
         slave_mode_o      <= cfg_slave;
         subsample_o       <= cfg_subsample;
         binning_o         <= cfg_binning;
         rs_x_length_o     <= delay_cfg[DLY_XLEN_LSB +: DELAY_W];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Readout start placement after the row overhead period.
   readout_delay #(
      .LEN_W          (DELAY_W)
   ) start_delay (
      .clk_i          (clk_i),
      .sys_rst_i      (sys_rst_i),
      .run_i          (seq_enable_o),
      .overhead_end_i (row_overhead_period_end_i),
      .delay_en_i     (cfg_delay_en),
      .delay_len_i    (readout_delay_len),
      .start_o        (readout_start_o)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read decode; unmapped and reserved offsets return zero.
   logic [DATA_W-1:0] read_word;

   always_comb
   begin
      unique case (reg_addr_i)
         PIX_COUNT_LOW_ADDR:  read_word = pix_low_word;
         PIX_COUNT_HIGH_ADDR: read_word = pix_high_word;
         AEC_AVERAGE_ADDR:    read_word = average_word;
         AEC_EXPOSURE_ADDR:   read_word = exposure_word;
         AEC_GAIN_ADDR:       read_word = gain_word;
         SEQ_GENERAL_ADDR:    read_word = general_cfg;
         SEQ_DELAY_ADDR:      read_word = delay_cfg;
         default:             read_word = STATUS_RESET;
      endcase
   end

   // Read data is held until the next read.
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         reg_rdata_o  <= '0;
         reg_rvalid_o <= 1'b0;
      end
      else
      begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i)
            reg_rdata_o <= read_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the register bank and the readout start.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   a_read_low_count: assert property (
      reg_rd_i && reg_addr_i == PIX_COUNT_LOW_ADDR |=> reg_rvalid_o && reg_rdata_o == $past(pix_count[15:0]))
      else $error("Low pixel count read back wrong.");

   a_read_high_count: assert property (
      reg_rd_i && reg_addr_i == PIX_COUNT_HIGH_ADDR
      |=> reg_rdata_o[15:3] == 13'h0000 && reg_rdata_o[2:0] == $past(pix_count[18:16]))
      else $error("High pixel count read back wrong.");

   a_read_average_lock: assert property (
      reg_rd_i && reg_addr_i == AEC_AVERAGE_ADDR
      |=> reg_rdata_o[9:0] == $past(average) && reg_rdata_o[12] == $past(locked)
          && reg_rdata_o[15:13] == 3'h0 && reg_rdata_o[11:10] == 2'h0)
      else $error("Average status read back wrong.");

   a_read_gain_fields: assert property (
      reg_rd_i && reg_addr_i == AEC_GAIN_ADDR
      |=> reg_rdata_o[1:0] == $past(amp_first) && reg_rdata_o[3:2] == $past(amp_second)
          && reg_rdata_o[15:4] == $past(digital_gain))
      else $error("Gain status read back wrong.");

   // The read strobe is answered by exactly one valid cycle, and the data then stand.
   a_rvalid_after_read: assert property (
      reg_rd_i |=> reg_rvalid_o)
      else $error("Read strobe not answered by valid.");

   a_rvalid_no_read: assert property (
      !reg_rd_i |=> !reg_rvalid_o)
      else $error("Valid raised without a read strobe.");

   a_rdata_held: assert property (
      !reg_rd_i |=> $stable(reg_rdata_o))
      else $error("Read data changed without a read.");

   a_enable_follows_cfg: assert property (
      wr_general ##1 !wr_general |=> seq_enable_o == $past(reg_wdata_i[CFG_ENABLE_BIT], 2))
      else $error("Sequencer enable does not follow the written bit.");

   a_rolling_blocks_modes: assert property (
      rolling_shutter_o |-> !triggered_mode_o && !slave_mode_o)
      else $error("Trigger or slave active under rolling shutter.");

   a_triggered_global: assert property (
      wr_general ##1 !wr_general |=> triggered_mode_o == ($past(reg_wdata_i[CFG_TRIGGERED_BIT], 2)
                                     && !$past(reg_wdata_i[CFG_ROLLING_BIT], 2)))
      else $error("Triggered mode does not follow the written bits.");

   a_no_delay_start: assert property (
      row_overhead_period_end_i && seq_enable_o && !cfg_delay_en ##1 seq_enable_o |-> readout_start_o)
      else $error("Readout start missing one cycle after overhead end.");

   a_delay_holds_start: assert property (
      row_overhead_period_end_i && seq_enable_o && cfg_delay_en && readout_delay_len != 8'h00
      |=> !readout_start_o)
      else $error("Readout started without the programmed delay.");

   // Readout start is a single pulse and never comes while the sequencer idles.
   a_idle_no_start: assert property (
      !seq_enable_o |=> !readout_start_o)
      else $error("Readout started while the sequencer was idle.");

   a_start_single: assert property (
      readout_start_o && !row_overhead_period_end_i |=> !readout_start_o)
      else $error("Readout start lasted more than one cycle.");

   a_delay_one_start: assert property (
      row_overhead_period_end_i && seq_enable_o && cfg_delay_en && readout_delay_len == 8'h01
      ##1 seq_enable_o && !row_overhead_period_end_i |=> readout_start_o)
      else $error("Readout start missing after a one-cycle delay.");

   a_bin_follows_cfg: assert property (
      wr_general ##1 !wr_general |=> binning_o == $past(reg_wdata_i[CFG_BINNING_BIT], 2)
                                     && subsample_o == $past(reg_wdata_i[CFG_SUBSAMPLE_BIT], 2))
      else $error("Subsample or binning does not follow the written bits.");

   a_status_write_ignored: assert property (
      wr_status && !aec_update_i
      |=> $stable(pix_low_word) && $stable(pix_high_word) && $stable(average_word)
          && $stable(exposure_word) && $stable(gain_word))
      else $error("Write changed a status register.");

   a_reserved_cfg_zero: assert property (
      (general_cfg & ~SEQ_GENERAL_MASK) == 16'h0000)
      else $error("Reserved configuration bits are not zero.");

   // The stored configuration words follow the write data, reserved bits masked off.
   a_general_write_mask: assert property (
      wr_general |=> general_cfg == ($past(reg_wdata_i) & SEQ_GENERAL_MASK))
      else $error("General configuration not stored as written.");

   a_delay_write_store: assert property (
      wr_delay |=> delay_cfg == $past(reg_wdata_i))
      else $error("Delay configuration not stored as written.");

   // Main scenarios that the tests are meant to reach.
   c_delayed_start: cover property (
      row_overhead_period_end_i && seq_enable_o && cfg_delay_en && readout_delay_len == 8'h03 ##4 readout_start_o);
   c_gain_read: cover property (reg_rd_i && reg_addr_i == AEC_GAIN_ADDR && aec_update_i);
   c_triggered_slave: cover property (triggered_mode_o && slave_mode_o && seq_enable_o);
   c_rolling_binned: cover property (rolling_shutter_o && binning_o && subsample_o);

endmodule : aec_seq_regs
`default_nettype wire

// ### host_port_model.sv
// Host controller model that issues register reads and writes on the configuration port.
`timescale 1ns/1ns
`default_nettype none
module host_port_model
   import aec_seq_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic [DATA_W-1:0] reg_rdata_i,
   input  wire logic              reg_rvalid_i,
   output logic      [ADDR_W-1:0] reg_addr_o,
   output logic      [DATA_W-1:0] reg_wdata_o,
   output logic                   reg_wr_o,
   output logic                   reg_rd_o
);
   ////////////////////////////////////////////////////////////////////////////
   // The bus starts idle with both strobes low.
   initial
   begin
      reg_addr_o  = 8'h00;
      reg_wdata_o = 16'h0000;
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
   end

   // One write strobe; afterwards address and data are scrambled so stale values cannot pass for live ones.
   task automatic wr_reg(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
      @(negedge clk_i);
      reg_addr_o  = addr;
      reg_wdata_o = data;
      reg_wr_o    = 1'b1;
      @(negedge clk_i);
      reg_wr_o    = 1'b0;
      reg_addr_o  = ~addr;
      reg_wdata_o = ~data;
   endtask : wr_reg

   // One read strobe; the answer is taken in the following cycle, the only one in which valid stands.
   task automatic rd_reg(input logic [ADDR_W-1:0] addr, output logic [DATA_W-1:0] data, output logic ok);
      @(negedge clk_i);
      reg_addr_o = addr;
      reg_rd_o   = 1'b1;
      @(negedge clk_i);
      reg_rd_o   = 1'b0;
      reg_addr_o = ~addr;
      ok         = reg_rvalid_i;
      data       = reg_rdata_i;
   endtask : rd_reg
endmodule : host_port_model
`default_nettype wire

// ### aec_status_sequencer_config_tb.sv
// Self-checking testbench of the exposure status and sequencer configuration registers.
`timescale 1ns/1ns
`default_nettype none
module aec_status_sequencer_config_tb;
   import aec_seq_pkg::*;

   logic              clk_i, sys_rst_i, upd, ov_end, rvalid, start;
   logic              en, roll, trig, slv, subs, binn;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata;
   logic              wr, rd;
   logic [7:0]        xlen;
   int                error_cnt, checked, cnt, avg, lck, expo, a1, a2, dg, cfg, dly;
   logic [7:0]        addrs [9] = '{8'hb8, 8'hb9, 8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hc0, 8'hc1, 8'hc7};

   ////////////////////////////////////////////////////////////////////////////
   // Device, host model and clock.
   aec_seq_regs dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .aec_update_i(upd),
      .aec_pixel_count_i(cnt[18:0]), .aec_average_i(avg[9:0]), .aec_locked_i(lck[0]),
      .aec_exposure_i(expo[15:0]), .analog_amp_first_i(a1[1:0]), .analog_amp_second_i(a2[1:0]),
      .aec_digital_gain_i(dg[11:0]), .row_overhead_period_end_i(ov_end), .seq_enable_o(en),
      .rolling_shutter_o(roll), .triggered_mode_o(trig), .slave_mode_o(slv), .subsample_o(subs),
      .binning_o(binn), .rs_x_length_o(xlen), .readout_start_o(start));
   host_port_model host_u (.clk_i(clk_i), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid), .reg_addr_o(addr),
      .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));

   // Free-running 10 MHz clock.
   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reference model of what each register reads back.
   function automatic logic [15:0] exp_rd(input logic [7:0] a);
      case (a)
         8'hb8: return cnt[15:0];
         8'hb9: return {13'h0000, cnt[18:16]};
         8'hba: return {3'h0, lck[0], 2'h0, avg[9:0]};
         8'hbb: return expo[15:0];
         8'hbc: return {dg[11:0], a2[1:0], a1[1:0]};
         8'hc0: return cfg[15:0] & 16'h01f3;
         8'hc1: return dly[15:0];
         default: return 16'h0000;
      endcase
   endfunction : exp_rd

   // Counts one comparison and reports a mismatch at once.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // Reads every mapped place plus an unmapped one and compares each with the model.
   task automatic sweep();
      logic [15:0] d;
      logic        ok;
      foreach (addrs[i])
      begin
         host_u.rd_reg(addrs[i], d, ok);
         chk({31'h0, ok}, 32'h1, "read valid");
         chk({16'h0, d}, {16'h0, exp_rd(addrs[i])}, "read data");
      end
   endtask : sweep

   // Pulses the overhead end and counts cycles until readout starts; zero means it never came.
   task automatic readout(input int exp_k);
      int k;
      k = 0;
      @(negedge clk_i);
      ov_end = 1'b1;
      @(negedge clk_i);
      ov_end = 1'b0;
      for (int i = 1; i <= 300 && k == 0; i++)
      begin
         if (start === 1'b1)
            k = i;
         else
            @(negedge clk_i);
      end
      chk(k, exp_k, "readout start cycle");
      @(negedge clk_i);
      chk({31'h0, start}, 32'h0, "readout start width");
   endtask : readout

   // Verdict, printed once at the end of the run or by the watchdog.
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog against a hung run.
   initial
   begin
      #2000000;
      error_cnt++;
      conclude();
   end

   // Main sequence: reset values, status snapshots, configuration fields, readout delay.
   initial
   begin
      int v;
      int d;
      {upd, ov_end, cnt, avg, lck, expo, a1, a2, dg, cfg, dly, error_cnt, checked} = '0;
      void'($urandom(41423));
      sys_rst_i = 1'b1;
      repeat (6) @(negedge clk_i);
      sys_rst_i = 1'b0;
      sweep();
      for (int n = 0; n < 4; n++)
      begin
         @(negedge clk_i);
         {cnt, avg, expo} = {$urandom % 32'h80000, $urandom % 1024, $urandom % 65536};
         {lck, a1, a2, dg} = {$urandom % 2, $urandom % 4, $urandom % 4, $urandom % 4096};
         upd = 1'b1;
         @(negedge clk_i);
         upd = 1'b0;
         for (int i = 0; i < 6; i++)
            host_u.wr_reg(addrs[i], ~exp_rd(addrs[i]));
         sweep();
      end
      for (int n = 0; n < 8; n++)
      begin
         cfg = (n < 2) ? 32'hffff * (n % 2) : $urandom % 65536;
         host_u.wr_reg(8'hc0, cfg[15:0]);
         @(negedge clk_i);
         chk({en, roll, subs, binn}, {cfg[0], cfg[1], cfg[7], cfg[8]}, "mode outputs");
         chk({trig, slv}, {cfg[4] & ~cfg[1], cfg[5] & ~cfg[1]}, "global only modes");
         sweep();
      end
      // Each row: delay insert, delay byte; row 4 clears enable, row 5 sets rolling shutter, and the start cycle is worked out from them.
      for (int n = 0; n < 7; n++)
      begin
         v = (n == 0) ? 32'h01050 : (n == 1) ? 32'h11030 : (n == 2) ? 32'h11000 : (n == 3) ? 32'h11ff0
           : (n == 6) ? 32'h11010 : 32'h01030;
         d = v[11:4];
         dly = (d << 8) | ($urandom % 256);
         cfg = (v[16] ? 32'h0040 : 32'h0) | (n == 4 ? 32'h0 : 32'h0001) | (n == 5 ? 32'h0002 : 32'h0);
         host_u.wr_reg(8'hc1, dly[15:0]);
         host_u.wr_reg(8'hc0, cfg[15:0]);
         @(negedge clk_i);
         chk({24'h0, xlen}, dly[7:0], "x length");
         sweep();
         readout((n == 4) ? 0 : (v[16] && d != 0) ? d + 1 : 1);
      end
      conclude();
   end
endmodule : aec_status_sequencer_config_tb
`default_nettype wire
